// ---- logic/byte_match.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// equality of one compare byte against one counter byte
// ============================================================
module byte_match (
  input  wire logic [7:0] compare_in, // stored compare byte
  input  wire logic [7:0] count_in,   // live counter byte
  output logic            equal_out   // high while both agree
);

  // plain comparator; the caller qualifies it with the tick
  always_comb begin
    equal_out = (compare_in == count_in);
  end

endmodule
`default_nettype wire

// ---- logic/timer_compare_pkg.sv ----
`default_nettype none
// ============================================================
// shared constants of the output-compare section
// ============================================================
package timer_compare_pkg;

  // ==========================================================
  // bus geometry
  // ==========================================================
  localparam int unsigned ADDR_W   = 3;   // register index width
  localparam int unsigned DATA_W   = 8;   // cpu data width
  localparam int unsigned COUNT_W  = 16;  // counter / compare width
  localparam int unsigned HALVES   = 2;   // byte halves of the word
  localparam int unsigned FLAG_W   = 2;   // one flag per half

  // ==========================================================
  // register indices
  // ==========================================================
  localparam logic [2:0] ADDR_CMP_HIGH = 3'h0; // compare_value_high_byte
  localparam logic [2:0] ADDR_CMP_LOW  = 3'h1; // compare_value_low_byte
  localparam logic [2:0] ADDR_CTRL     = 3'h2; // timer_control_register
  localparam logic [2:0] ADDR_STATUS   = 3'h3; // timer_status_register
  localparam logic [2:0] ADDR_IRQ_REQ  = 3'h4; // irq_request_register
  localparam logic [2:0] ADDR_IRQ_EN   = 3'h5; // irq_enable_register

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int unsigned HALF_LOW      = 0; // low half / bit 0 flags
  localparam int unsigned HALF_HIGH     = 1; // high half / bit 1 flags
  localparam int unsigned CTRL_TOL_LOW  = 0; // out_level_low
  localparam int unsigned CTRL_TOL_HIGH = 1; // out_level_high
  localparam int unsigned CTRL_WIDTH    = 4; // width_select_bit

  // ==========================================================
  // reset values and masks
  // ==========================================================
  localparam logic [7:0] CMP_RESET  = 8'hFF; // compare bytes at reset
  localparam logic [7:0] TEMP_RESET = 8'hFF; // temporary byte at reset
  localparam logic [7:0] CTRL_RESET = 8'h00; // 16-bit mode, low levels
  localparam logic [7:0] CTRL_MASK  = 8'h13; // implemented control bits
  localparam logic [7:0] READ_ZERO  = 8'h00; // idle / unmapped read
  localparam logic [1:0] FLAG_RESET = 2'h0;  // flags clear at reset
  localparam logic [1:0] PIN_RESET  = 2'h0;  // pins low at reset

endpackage
`default_nettype wire

// ---- logic/timer_output_compare_unit.sv ----
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// output-compare section of a 16-bit timer
// ============================================================
module timer_output_compare_unit (
  input  wire logic        clk_in,                   // system clock
  input  wire logic        resetn_in,                // async reset
  input  wire logic [2:0]  addr_in,                  // register index
  input  wire logic [7:0]  wr_data_in,               // write data
  input  wire logic        wr_strobe_in,             // write strobe
  input  wire logic        rd_strobe_in,             // read strobe
  output logic      [7:0]  rd_data_out,              // read data
  input  wire logic [15:0] counter_word_in,          // running counter
  input  wire logic        counter_tick_in,          // counter updated
  output logic             compare_out_high_pin_out, // high toggle pin
  output logic             compare_out_low_pin_out,  // low toggle pin
  output logic             irq_out                   // level interrupt
);

  // ==========================================================
  // state
  // ==========================================================
  logic [1:0][7:0] cmp_r;        // compare bytes, index by half
  logic [1:0][7:0] cmp_nxt;
  logic [7:0]      temp_r;       // temporary byte for word access
  logic [7:0]      temp_nxt;
  logic [7:0]      ctrl_r;       // timer_control_register
  logic [7:0]      ctrl_nxt;
  logic [1:0]      match_flag_r; // timer_status_register flags
  logic [1:0]      match_flag_nxt;
  logic [1:0]      irq_req_r;    // irq_request_register
  logic [1:0]      irq_req_nxt;
  logic [1:0]      irq_en_r;     // irq_enable_register, the mask
  logic [1:0]      irq_en_nxt;
  logic [1:0]      pin_r;        // toggle pins, index by half
  logic [1:0]      pin_nxt;
  logic            irq_r;        // registered interrupt line
  logic            irq_nxt;
  logic [7:0]      rd_data_r;    // registered read answer
  logic [7:0]      rd_data_nxt;

  // ==========================================================
  // decode
  // ==========================================================
  logic       split_mode;  // width_select_bit set: two byte compares
  logic [1:0] byte_equal;  // per-half equality
  logic [1:0] hit;         // qualified match events, one per half
  logic       wr_ctrl;     // write to the control register
  logic       wr_status;   // write-one-to-clear of match flags
  logic       wr_req;      // write-one-to-clear of request flags

  always_comb begin
    split_mode = ctrl_r[timer_compare_pkg::CTRL_WIDTH];
    wr_ctrl    = wr_strobe_in &&
                 (addr_in == timer_compare_pkg::ADDR_CTRL);
    wr_status  = wr_strobe_in &&
                 (addr_in == timer_compare_pkg::ADDR_STATUS);
    wr_req     = wr_strobe_in &&
                 (addr_in == timer_compare_pkg::ADDR_IRQ_REQ);
  end

  // ==========================================================
  // per-half comparators
  // ==========================================================
  // each half compares its stored byte with its counter byte;
  // the word compare is simply both halves equal at once
  genvar h;
  generate
    for (h = 0; h < timer_compare_pkg::HALVES; h = h + 1) begin : g_half
      byte_match u_match (
        .compare_in (cmp_r[h]),
        .count_in   (counter_word_in[h*8 +: 8]),
        .equal_out  (byte_equal[h])
      );
    end
  endgenerate

  // ==========================================================
  // match events
  // ==========================================================
  // a match only counts in the cycle the counter takes a new
  // value, so a counter parked on the compare value does not
  // re-fire every clock
  always_comb begin
    hit = '0;
    if (counter_tick_in) begin
      if (split_mode) begin
        // independent byte compares
        hit[timer_compare_pkg::HALF_HIGH] =
          byte_equal[timer_compare_pkg::HALF_HIGH];
        hit[timer_compare_pkg::HALF_LOW]  =
          byte_equal[timer_compare_pkg::HALF_LOW];
      end else begin
        // whole word must agree; the low half stays silent
        hit[timer_compare_pkg::HALF_HIGH] = &byte_equal;
      end
    end
  end

  // ==========================================================
  // compare bytes, temporary byte, control and mask
  // ==========================================================
  // in word mode the high byte is written first into the
  // temporary byte and lands together with the low byte; a read
  // of the low byte parks the high byte in the temporary byte so
  // that the following high read sees the same word even if
  // software wrote only the low byte in between
  always_comb begin
    cmp_nxt    = cmp_r;
    temp_nxt   = temp_r;
    ctrl_nxt   = ctrl_r;
    irq_en_nxt = irq_en_r;
    if (wr_strobe_in) begin
      case (addr_in)
        timer_compare_pkg::ADDR_CMP_HIGH: begin
          if (split_mode) begin
            // direct 8-bit register
            cmp_nxt[timer_compare_pkg::HALF_HIGH] = wr_data_in;
          end else begin
            // held until the low byte arrives
            temp_nxt = wr_data_in;
          end
        end
        timer_compare_pkg::ADDR_CMP_LOW: begin
          cmp_nxt[timer_compare_pkg::HALF_LOW] = wr_data_in;
          if (!split_mode) begin
            // both bytes change in the same edge
            cmp_nxt[timer_compare_pkg::HALF_HIGH] = temp_r;
          end
        end
        timer_compare_pkg::ADDR_CTRL: begin
          // unused bits are not stored and read as zero
          ctrl_nxt = wr_data_in & timer_compare_pkg::CTRL_MASK;
        end
        timer_compare_pkg::ADDR_IRQ_EN: begin
          irq_en_nxt = wr_data_in[1:0];
        end
        default: begin
          // other indices: nothing stored here
        end
      endcase
    end else if (rd_strobe_in && !split_mode &&
                 (addr_in == timer_compare_pkg::ADDR_CMP_LOW)) begin
      // low read first, high byte snapshotted for the next read
      temp_nxt = cmp_r[timer_compare_pkg::HALF_HIGH];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmp_r    <= {timer_compare_pkg::CMP_RESET,
                   timer_compare_pkg::CMP_RESET};
      temp_r   <= timer_compare_pkg::TEMP_RESET;
      ctrl_r   <= timer_compare_pkg::CTRL_RESET;
      irq_en_r <= timer_compare_pkg::FLAG_RESET;
    end else begin
      cmp_r    <= cmp_nxt;
      temp_r   <= temp_nxt;
      ctrl_r   <= ctrl_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // ==========================================================
  // sticky match and request flags, interrupt line
  // ==========================================================
  // a flag set by a match in the same cycle as software writes
  // one to clear it stays set: the event is never lost
  always_comb begin
    match_flag_nxt = match_flag_r;
    irq_req_nxt    = irq_req_r;
    for (int i = 0; i < timer_compare_pkg::FLAG_W; i++) begin
      // clear by writing one
      if (wr_status && wr_data_in[i]) begin
        match_flag_nxt[i] = 1'b0;
      end
      if (wr_req && wr_data_in[i]) begin
        irq_req_nxt[i] = 1'b0;
      end
      // set wins over clear
      if (hit[i]) begin
        match_flag_nxt[i] = 1'b1;
        irq_req_nxt[i]    = 1'b1;
      end
    end
    // registered from next values so the line rises one edge
    // after the match, together with the flag
    irq_nxt = |(irq_req_nxt & irq_en_nxt);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      match_flag_r <= timer_compare_pkg::FLAG_RESET;
      irq_req_r    <= timer_compare_pkg::FLAG_RESET;
      irq_r        <= 1'b0;
    end else begin
      match_flag_r <= match_flag_nxt;
      irq_req_r    <= irq_req_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // ==========================================================
  // toggle pins
  // ==========================================================
  // writing the control register loads both pins with their
  // selected levels; later matches invert them. a match in the
  // very cycle of a control write is dropped on purpose, so the
  // level software just chose is what the pin shows
  always_comb begin
    pin_nxt = pin_r;
    if (wr_ctrl) begin
      pin_nxt[timer_compare_pkg::HALF_HIGH] =
        wr_data_in[timer_compare_pkg::CTRL_TOL_HIGH];
      pin_nxt[timer_compare_pkg::HALF_LOW]  =
        wr_data_in[timer_compare_pkg::CTRL_TOL_LOW];
    end else begin
      pin_nxt = pin_r ^ hit;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_r <= timer_compare_pkg::PIN_RESET;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // ==========================================================
  // read port
  // ==========================================================
  // answer stands only in the cycle after the strobe; zero at
  // every other time and for indices that hold nothing
  always_comb begin
    rd_data_nxt = timer_compare_pkg::READ_ZERO;
    if (rd_strobe_in) begin
      case (addr_in)
        timer_compare_pkg::ADDR_CMP_HIGH: begin
          if (split_mode) begin
            rd_data_nxt = cmp_r[timer_compare_pkg::HALF_HIGH];
          end else begin
            // word mode: the byte parked by the low read
            rd_data_nxt = temp_r;
          end
        end
        timer_compare_pkg::ADDR_CMP_LOW: begin
          rd_data_nxt = cmp_r[timer_compare_pkg::HALF_LOW];
        end
        timer_compare_pkg::ADDR_CTRL: begin
          rd_data_nxt = ctrl_r;
        end
        timer_compare_pkg::ADDR_STATUS: begin
          rd_data_nxt[1:0] = match_flag_r;
        end
        timer_compare_pkg::ADDR_IRQ_REQ: begin
          rd_data_nxt[1:0] = irq_req_r;
        end
        timer_compare_pkg::ADDR_IRQ_EN: begin
          rd_data_nxt[1:0] = irq_en_r;
        end
        default: begin
          // unmapped: reads as zero
          rd_data_nxt = timer_compare_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_r <= timer_compare_pkg::READ_ZERO;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  // ==========================================================
  always_comb begin
    rd_data_out              = rd_data_r;
    compare_out_high_pin_out = pin_r[timer_compare_pkg::HALF_HIGH];
    compare_out_low_pin_out  = pin_r[timer_compare_pkg::HALF_LOW];
    irq_out                  = irq_r;
  end

endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// compare one value, count it, report a mismatch at once
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic        clk_in = 1'b0;          // 40 MHz system clock
  logic        resetn_in = 1'b0;       // held low at start
  logic [2:0]  addr_in = 3'h0;         // register index
  logic [7:0]  wr_data_in = 8'h00;     // write data
  logic        wr_strobe_in = 1'b0;    // write strobe
  logic        rd_strobe_in = 1'b0;    // read strobe
  logic [15:0] counter_word_in = 16'h0000; // counter stand-in
  logic        counter_tick_in = 1'b0; // counter update pulse
  logic [7:0]  rd_data_out;            // read answer
  logic        hi_pin;                 // high toggle pin
  logic        lo_pin;                 // low toggle pin
  logic        irq_out;                // interrupt level
  int          err_total = 0;          // mismatches
  int          check_count = 0;        // comparisons
  int          cycles = 0;             // timeout counter
  always #12.5 clk_in = ~clk_in;
  timer_output_compare_unit i_timer_output_compare_unit (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
    .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
    .counter_word_in(counter_word_in), .counter_tick_in(counter_tick_in),
    .compare_out_high_pin_out(hi_pin), .compare_out_low_pin_out(lo_pin),
    .irq_out(irq_out));
  // ==========================================================
  // bus and counter driver: one cycle per call
  // ==========================================================
  // inputs move just after an edge and are taken at the next one;
  // the task returns once that edge's updates have landed
  task automatic cyc(input logic w, input logic r, input logic [2:0] a,
                     input logic [7:0] d, input logic tk, input logic [15:0] c);
    wr_strobe_in <= w;
    rd_strobe_in <= r;
    addr_in <= a;
    wr_data_in <= d;
    counter_tick_in <= tk;
    counter_word_in <= c;
    @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d, 1'b0, counter_word_in);
  endtask
  task automatic tick(input logic [15:0] c);
    cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b1, c);
  endtask
  // read answer stands only in the following cycle, sampled there
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    cyc(1'b0, 1'b1, a, 8'h00, 1'b0, counter_word_in);
    `CHK(nm, e, rd_data_out)
  endtask
  task automatic outs(input logic [2:0] e, input string nm);
    cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0, counter_word_in);
    `CHK(nm, e, {hi_pin, lo_pin, irq_out})
  endtask
  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset;
    outs(3'b000, "reset outputs");
    rd(3'h1, 8'hFF, "reset low byte");
    rd(3'h0, 8'hFF, "reset high byte");
    $display("test reset done");
  endtask
  task automatic t_word;
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    rd(3'h1, 8'h34, "word low");
    rd(3'h0, 8'h12, "word high");
    $display("test word access done");
  endtask
  task automatic t_match16;
    wr(3'h5, 8'h03);
    cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0, 16'h1234); // equal but no tick
    rd(3'h3, 8'h00, "no tick status");
    tick(16'h1234);
    outs(3'b101, "word match pins");
    rd(3'h3, 8'h02, "word status");
    rd(3'h4, 8'h02, "word request");
    tick(16'h1334); // only the low byte agrees
    rd(3'h3, 8'h02, "half match ignored");
    wr(3'h4, 8'h02);
    outs(3'b100, "request cleared");
    tick(16'h1234);
    outs(3'b001, "second toggle");
    wr(3'h4, 8'h03);
    wr(3'h3, 8'h03);
    wr(3'h5, 8'h00);
    tick(16'h1234);
    outs(3'b100, "masked match");
    rd(3'h4, 8'h02, "masked request");
    wr(3'h4, 8'h03);
    $display("test word match done");
  endtask
  task automatic t_byte8;
    wr(3'h2, 8'h13);
    outs(3'b110, "start levels");
    wr(3'h0, 8'h56);
    rd(3'h0, 8'h56, "direct high");
    wr(3'h1, 8'h78);
    wr(3'h3, 8'h03);
    wr(3'h5, 8'h03);
    tick(16'h5600);
    outs(3'b011, "high half match");
    rd(3'h3, 8'h02, "high half status");
    tick(16'h0078);
    outs(3'b001, "low half match");
    rd(3'h4, 8'h03, "both requests");
    wr(3'h4, 8'h03);
    outs(3'b000, "requests cleared");
    rd(3'h6, 8'h00, "unmapped read");
    $display("test byte mode done");
  endtask
  // ==========================================================
  // closing report, reached once from either path
  // ==========================================================
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard: the scenarios need well under 200 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_word();
    t_match16();
    t_byte8();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- tb/timer_compare_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// port-level checker for the output-compare section
// ============================================================
module timer_compare_properties (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [2:0]  addr_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic        wr_strobe_in,
  input wire logic        rd_strobe_in,
  input wire logic [7:0]  rd_data_out,
  input wire logic [15:0] counter_word_in,
  input wire logic        counter_tick_in,
  input wire logic        compare_out_high_pin_out,
  input wire logic        compare_out_low_pin_out,
  input wire logic        irq_out
);
  // one domain, so one clocking and one reset for all
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // decoded bus events, kept as wires to shorten the properties
  wire logic ctl_wr;  // control register write
  wire logic irq_wr;  // request or enable write
  assign ctl_wr = wr_strobe_in &&
                  addr_in == timer_compare_pkg::ADDR_CTRL;
  assign irq_wr = wr_strobe_in &&
                  (addr_in == timer_compare_pkg::ADDR_IRQ_REQ ||
                   addr_in == timer_compare_pkg::ADDR_IRQ_EN);
  // ==========================================================
  // bus answers
  // ==========================================================
  rd_idle_zero_a: assert property (
    !rd_strobe_in |=> rd_data_out == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (rd_strobe_in && addr_in > 3'h5
    |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
  flag_pad_a: assert property (rd_strobe_in && (addr_in == 3'h3 ||
    addr_in == 3'h4) |=> rd_data_out[7:2] == 6'h00)
    else $error("flag register upper bits not zero");
  // ==========================================================
  // pins: loaded by control writes, moved only by ticks
  // ==========================================================
  ctrl_level_a: assert property (
    ctl_wr |=> {compare_out_high_pin_out,
    compare_out_low_pin_out} == $past(wr_data_in[1:0]))
    else $error("control write did not load pin levels");
  high_pin_cause_a: assert property ($changed(compare_out_high_pin_out)
    |-> $past(counter_tick_in || ctl_wr)) else $error("high pin moved alone");
  low_pin_cause_a: assert property ($changed(compare_out_low_pin_out)
    |-> $past(counter_tick_in || ctl_wr)) else $error("low pin moved alone");
  // ==========================================================
  // interrupt level follows requests and enables
  // ==========================================================
  irq_rise_a: assert property ($rose(irq_out) |-> $past(counter_tick_in ||
    irq_wr)) else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(irq_wr))
    else $error("interrupt fell without a write");
endmodule
bind timer_output_compare_unit
  timer_compare_properties i_timer_compare_properties (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
  .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
  .counter_word_in(counter_word_in), .counter_tick_in(counter_tick_in),
  .compare_out_high_pin_out(compare_out_high_pin_out),
  .compare_out_low_pin_out(compare_out_low_pin_out), .irq_out(irq_out));
`default_nettype wire
